// ### hdl/intc_consts.vh
// Purpose: constants shared by the interrupt controller files
// Assumes: 8-bit special-function register port, one clock
// Notes:   register addresses are the printed special-function addresses
//
// Functional notes
// - two priority bits per source, msb from high
// - only strictly higher level pre-empts running routine
// - equal levels resolved by fixed hardware ranking
// - controller runs on the core clock
// - fourteen maskable sources, reset/trap/nmi never masked
// - global enable bit 7 blocks maskable sources
// - primary enable bits gate their sources
// - additional enable bits gate sources, bit7 zero
// - converter enable gates four ORed causes
// - any enabled pending interrupt wakes core from idle
// - only external requests wake from power-down
// - trigger bit selects low level or falling edge
// - edge flag cleared on vectoring, level by software
// - pins sampled every cycle, two-cycle level detected
// - accept: finish instruction, save pc, load vector
// - return clears in-progress level, restores pc
// - group flag follows its source pending bits
// - priority bits mirror enable positions, bit7 zero
// - external control flags set by hardware, write-one-clear
`ifndef INTC_CONSTS_VH
`define INTC_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_GROUP_FLAGS_A  8'h88
`define ADDR_PRIMARY_EN     8'ha8
`define ADDR_PRIO_MSB_A     8'hb7
`define ADDR_PRIO_LSB_A     8'hb8
`define ADDR_GROUP_FLAGS_B  8'hc0
`define ADDR_EXT_CTRL       8'hd8
`define ADDR_ADDITIONAL_EN  8'he8
`define ADDR_PRIO_MSB_B     8'hf7
`define ADDR_PRIO_LSB_B     8'hf8

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define GLOBAL_EN_BIT       7
`define EXT1_FLAG_BIT       3
`define EXT1_TRIG_BIT       2
`define EXT0_FLAG_BIT       1
`define EXT0_TRIG_BIT       0
`define RST_BYTE            8'h00
`define RST_FIELD7          7'h00
`define RST_LEVEL_MASK      5'h00
`define LEVEL_NONMASKABLE   3'h4

// ----------------------------------------
// vectors
// ----------------------------------------
`define VEC_BANK_HI         8'hff
`define VEC_BANK_LO         8'hfe
`define VEC_MID             8'h00
`define VEC_OFFSET          8'h03
`define VEC_RESET_ADDR      24'hfe_0000
`define VEC_TRAP            4'hf
`define VEC_NMI             4'h7
`define VEC_EXT0            4'h0
`define VEC_EXT1            4'h2

`endif

// ### hdl/ext_pin_sync.v
// Purpose: synchronise one external request pin and find its falling edge
// Assumes: pin is asynchronous to clk, idles high
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/1ps
module ext_pin_sync (
	input  wire clk,
	input  wire sys_rst,
	input  wire pin_raw,
	output wire level_low,
	output wire fall_pulse
);

	reg stage1_reg;
	reg stage2_reg;
	reg stage3_reg;
	reg stable_reg;
	reg fall_reg;

	// ----------------------------------------
	// three-stage sampler, every clock
	// ----------------------------------------
	// stage1 feeds stage2 only; metastability stays contained
	always @(posedge clk) begin
		if (sys_rst) begin
			stage1_reg <= 1'b1;
			stage2_reg <= 1'b1;
			stage3_reg <= 1'b1;
			stable_reg <= 1'b1;
			fall_reg   <= 1'b0;
		end else begin
			stage1_reg <= pin_raw;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			if (stage2_reg == stage3_reg) begin
				stable_reg <= stage3_reg;
			end
			fall_reg <= stable_reg & ~stage3_reg & ~stage2_reg;
		end
	end

	assign level_low  = ~stable_reg;
	assign fall_pulse = fall_reg;

endmodule

// ### hdl/irq_rank_resolver.v
// Purpose: pick the winning request by level, then by fixed rank
// Assumes: rank 0 is trap, rank 1 nmi, ranks 2..15 the maskable sources
// Notes:   purely combinational; a higher rank wins a tie
`timescale 1ns/1ps
`include "intc_consts.vh"
module irq_rank_resolver #(
	parameter N = 16
) (
	input  wire [N-1:0] req,
	input  wire [N-3:0] pri_msb,
	input  wire [N-3:0] pri_lsb,
	output reg          win_valid,
	output reg  [3:0]   win_rank,
	output reg  [2:0]   win_level
);

	wire [N-1:0] msb_ext;
	wire [N-1:0] lsb_ext;
	reg  [2:0]   lvl;
	integer      i;

	assign msb_ext = {pri_msb, 2'b00};
	assign lsb_ext = {pri_lsb, 2'b00};

	// ----------------------------------------
	// scan low rank to high, ties go upward
	// ----------------------------------------
	always @* begin
		win_valid = 1'b0;
		win_rank  = 4'h0;
		win_level = 3'h0;
		lvl       = 3'h0;
		for (i = 0; i < N; i = i + 1) begin
			if (i < 2) begin
				lvl = `LEVEL_NONMASKABLE;
			end else begin
				lvl = {1'b0, msb_ext[i], lsb_ext[i]};
			end
			if (req[i] && (!win_valid || lvl >= win_level)) begin
				win_valid = 1'b1;
				win_rank  = i[3:0];
				win_level = lvl;
			end
		end
	end

endmodule

// ### hdl/four_level_interrupt_controller.v
// Purpose: four-level interrupt controller beside the core
// Assumes: core accepts a request with irq_ack and signals return
// Notes:   register reads answer one cycle after the read strobe
`timescale 1ns/1ps
`include "intc_consts.vh"
module four_level_interrupt_controller (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire [7:0]  sfr_wdata,
	output wire [7:0]  sfr_rdata,
	input  wire        ext_request_pin_0,
	input  wire        ext_request_pin_1,
	input  wire        counter_timer_pend,
	input  wire        rtc_pend,
	input  wire        uart_pend,
	input  wire        infrared_receiver_pend,
	input  wire        spi_pend,
	input  wire        usb_pend,
	input  wire        dma5_pend,
	input  wire        dma4_pend,
	input  wire        lcd_pend,
	input  wire        wire_ctl_pend,
	input  wire        audio_adc_pend,
	input  wire        amp_overcurrent_pend,
	input  wire        classd_overcurrent_pend,
	input  wire        codec_pend,
	input  wire        dma012_pend,
	input  wire        nmi_req,
	input  wire        trap_req,
	input  wire        irq_ack,
	input  wire        return_from_interrupt,
	input  wire        vector_bank_hi,
	input  wire        idle_mode,
	input  wire        power_down_mode,
	output wire        irq_req,
	output wire [3:0]  irq_vec_num,
	output wire [23:0] irq_vec_addr,
	output wire [23:0] reset_vec_addr,
	output wire [4:0]  level_in_progress,
	output wire        idle_wake,
	output wire        power_down_wake
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// rank order differs from vector order; trap and nmi sit lowest
	function [3:0] rank_to_vec;
		input [3:0] rank;
		begin
			if (rank == 4'h0) begin
				rank_to_vec = `VEC_TRAP;
			end else if (rank == 4'h1) begin
				rank_to_vec = `VEC_NMI;
			end else if (rank <= 4'h8) begin
				rank_to_vec = rank - 4'h2;
			end else begin
				rank_to_vec = rank - 4'h1;
			end
		end
	endfunction

	// true when no routine of this level or above is running
	function level_beats;
		input [2:0] lvl;
		input [4:0] mask;
		begin
			level_beats = ((mask >> lvl) == 5'h00);
		end
	endfunction

	// drop the highest running level on return
	function [4:0] drop_top;
		input [4:0] mask;
		integer k;
		reg     done;
		begin
			drop_top = mask;
			done     = 1'b0;
			for (k = 4; k >= 0; k = k - 1) begin
				if (mask[k] && !done) begin
					drop_top[k] = 1'b0;
					done        = 1'b1;
				end
			end
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg  [7:0]  primary_irq_enables_reg;
	reg  [6:0]  additional_irq_enables_reg;
	reg  [6:0]  priority_msb_a_reg;
	reg  [6:0]  priority_lsb_a_reg;
	reg  [6:0]  priority_msb_b_reg;
	reg  [6:0]  priority_lsb_b_reg;
	reg         ext0_flag_reg;
	reg         ext1_flag_reg;
	reg         ext0_trigger_type_reg;
	reg         ext1_trigger_type_reg;
	reg  [4:0]  in_prog_reg;
	reg  [7:0]  sfr_rdata_reg;
	reg         irq_req_reg;
	reg  [3:0]  irq_vec_num_reg;
	reg  [2:0]  irq_level_reg;
	reg  [23:0] irq_vec_addr_reg;
	reg  [23:0] reset_vec_addr_reg;
	reg         idle_wake_reg;
	reg         power_down_wake_reg;

	reg         ext0_flag_next;
	reg         ext1_flag_next;
	reg  [4:0]  in_prog_next;
	reg         irq_req_next;
	reg  [7:0]  read_data;

	wire        ext0_low;
	wire        ext0_fall;
	wire        ext1_low;
	wire        ext1_fall;
	wire        converter_group_pend;
	wire [6:0]  pend_a;
	wire [6:0]  pend_b;
	wire        global_irq_enable;
	wire [6:0]  allowed_a;
	wire [6:0]  allowed_b;
	wire [15:0] req_rank;
	wire        win_valid;
	wire [3:0]  win_rank;
	wire [2:0]  win_level;
	wire [3:0]  win_vec;
	wire        wr_ext_ctrl;
	wire        taken;

	// ----------------------------------------
	// external request pins
	// ----------------------------------------
	ext_pin_sync u_sync0 (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.pin_raw    (ext_request_pin_0),
		.level_low  (ext0_low),
		.fall_pulse (ext0_fall)
	);

	ext_pin_sync u_sync1 (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.pin_raw    (ext_request_pin_1),
		.level_low  (ext1_low),
		.fall_pulse (ext1_fall)
	);

	// ----------------------------------------
	// pending and enable gating
	// ----------------------------------------
	// converter causes share one request line
	assign converter_group_pend = wire_ctl_pend | audio_adc_pend
		| amp_overcurrent_pend | classd_overcurrent_pend;

	// bit order matches the enable and priority registers
	assign pend_a = {spi_pend, infrared_receiver_pend, uart_pend, rtc_pend,
		ext1_flag_reg, counter_timer_pend, ext0_flag_reg};
	assign pend_b = {dma012_pend, codec_pend, converter_group_pend, lcd_pend,
		dma4_pend, dma5_pend, usb_pend};

	assign global_irq_enable = primary_irq_enables_reg[`GLOBAL_EN_BIT];
	assign allowed_a = pend_a & primary_irq_enables_reg[6:0]
		& {7{global_irq_enable}};
	assign allowed_b = pend_b & additional_irq_enables_reg
		& {7{global_irq_enable}};

	// trap and nmi bypass every enable
	assign req_rank = {allowed_b, allowed_a, nmi_req, trap_req};

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	irq_rank_resolver #(
		.N (16)
	) u_resolver (
		.req       (req_rank),
		.pri_msb   ({priority_msb_b_reg, priority_msb_a_reg}),
		.pri_lsb   ({priority_lsb_b_reg, priority_lsb_a_reg}),
		.win_valid (win_valid),
		.win_rank  (win_rank),
		.win_level (win_level)
	);

	assign win_vec = rank_to_vec(win_rank);
	assign taken   = irq_ack & irq_req_reg;

	// ----------------------------------------
	// external flag next values
	// ----------------------------------------
	assign wr_ext_ctrl = sfr_wr && (sfr_addr == `ADDR_EXT_CTRL);

	// set wins over a same-cycle clear; a pin still low re-sets a level-triggered flag
	always @* begin
		ext0_flag_next = ext0_flag_reg;
		ext1_flag_next = ext1_flag_reg;
		if (wr_ext_ctrl && sfr_wdata[`EXT0_FLAG_BIT]) begin
			ext0_flag_next = 1'b0;
		end
		if (wr_ext_ctrl && sfr_wdata[`EXT1_FLAG_BIT]) begin
			ext1_flag_next = 1'b0;
		end
		if (taken && ext0_trigger_type_reg && irq_vec_num_reg == `VEC_EXT0) begin
			ext0_flag_next = 1'b0;
		end
		if (taken && ext1_trigger_type_reg && irq_vec_num_reg == `VEC_EXT1) begin
			ext1_flag_next = 1'b0;
		end
		if (ext0_trigger_type_reg ? ext0_fall : ext0_low) begin
			ext0_flag_next = 1'b1;
		end
		if (ext1_trigger_type_reg ? ext1_fall : ext1_low) begin
			ext1_flag_next = 1'b1;
		end
	end

	// ----------------------------------------
	// in-progress levels and request
	// ----------------------------------------
	// return is applied before a same-cycle acceptance
	always @* begin
		in_prog_next = in_prog_reg;
		if (return_from_interrupt) begin
			in_prog_next = drop_top(in_prog_reg);
		end
		if (taken) begin
			in_prog_next = in_prog_next | (5'h01 << irq_level_reg);
		end
		irq_req_next = win_valid && !irq_ack
			&& level_beats(win_level, in_prog_reg);
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// unmapped addresses and reserved bits read as zero
	always @* begin
		case (sfr_addr)
			`ADDR_GROUP_FLAGS_A: read_data = {1'b0, pend_a};
			`ADDR_GROUP_FLAGS_B: read_data = {1'b0, pend_b};
			`ADDR_PRIMARY_EN:    read_data = primary_irq_enables_reg;
			`ADDR_ADDITIONAL_EN: read_data = {1'b0, additional_irq_enables_reg};
			`ADDR_PRIO_MSB_A:    read_data = {1'b0, priority_msb_a_reg};
			`ADDR_PRIO_LSB_A:    read_data = {1'b0, priority_lsb_a_reg};
			`ADDR_PRIO_MSB_B:    read_data = {1'b0, priority_msb_b_reg};
			`ADDR_PRIO_LSB_B:    read_data = {1'b0, priority_lsb_b_reg};
			`ADDR_EXT_CTRL:      read_data = {4'h0, ext1_flag_reg, ext1_trigger_type_reg,
				ext0_flag_reg, ext0_trigger_type_reg};
			default:             read_data = `RST_BYTE;
		endcase
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// same clock as the core, no crossing needed
	always @(posedge clk) begin
		if (sys_rst) begin
			primary_irq_enables_reg    <= `RST_BYTE;
			additional_irq_enables_reg <= `RST_FIELD7;
			priority_msb_a_reg         <= `RST_FIELD7;
			priority_lsb_a_reg         <= `RST_FIELD7;
			priority_msb_b_reg         <= `RST_FIELD7;
			priority_lsb_b_reg         <= `RST_FIELD7;
			ext0_trigger_type_reg      <= 1'b0;
			ext1_trigger_type_reg      <= 1'b0;
		end else if (sfr_wr) begin
			case (sfr_addr)
				`ADDR_PRIMARY_EN:    primary_irq_enables_reg <= sfr_wdata;
				`ADDR_ADDITIONAL_EN: additional_irq_enables_reg <= sfr_wdata[6:0];
				`ADDR_PRIO_MSB_A:    priority_msb_a_reg <= sfr_wdata[6:0];
				`ADDR_PRIO_LSB_A:    priority_lsb_a_reg <= sfr_wdata[6:0];
				`ADDR_PRIO_MSB_B:    priority_msb_b_reg <= sfr_wdata[6:0];
				`ADDR_PRIO_LSB_B:    priority_lsb_b_reg <= sfr_wdata[6:0];
				`ADDR_EXT_CTRL: begin
					ext0_trigger_type_reg <= sfr_wdata[`EXT0_TRIG_BIT];
					ext1_trigger_type_reg <= sfr_wdata[`EXT1_TRIG_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// flags, levels, core-facing outputs
	// ----------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			ext0_flag_reg       <= 1'b0;
			ext1_flag_reg       <= 1'b0;
			in_prog_reg         <= `RST_LEVEL_MASK;
			sfr_rdata_reg       <= `RST_BYTE;
			irq_req_reg         <= 1'b0;
			irq_vec_num_reg     <= 4'h0;
			irq_level_reg       <= 3'h0;
			irq_vec_addr_reg    <= `VEC_RESET_ADDR;
			reset_vec_addr_reg  <= `VEC_RESET_ADDR;
			idle_wake_reg       <= 1'b0;
			power_down_wake_reg <= 1'b0;
		end else begin
			ext0_flag_reg      <= ext0_flag_next;
			ext1_flag_reg      <= ext1_flag_next;
			in_prog_reg        <= in_prog_next;
			reset_vec_addr_reg <= `VEC_RESET_ADDR;
			if (sfr_rd) begin
				sfr_rdata_reg <= read_data;
			end
			irq_req_reg <= irq_req_next;
			// vector is reloaded from the current winner every cycle the request is raised
			if (irq_req_next) begin
				irq_vec_num_reg  <= win_vec;
				irq_level_reg    <= win_level;
				irq_vec_addr_reg <= {vector_bank_hi ? `VEC_BANK_HI : `VEC_BANK_LO,
					`VEC_MID, {1'b0, win_vec, 3'b000} + `VEC_OFFSET};
			end
			idle_wake_reg <= idle_mode && (req_rank != 16'h0000);
			// only the external flags may end power-down
			power_down_wake_reg <= power_down_mode && global_irq_enable
				&& (allowed_a[0] || allowed_a[2]);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign sfr_rdata         = sfr_rdata_reg;
	assign irq_req           = irq_req_reg;
	assign irq_vec_num       = irq_vec_num_reg;
	assign irq_vec_addr      = irq_vec_addr_reg;
	assign reset_vec_addr    = reset_vec_addr_reg;
	assign level_in_progress = in_prog_reg;
	assign idle_wake         = idle_wake_reg;
	assign power_down_wake   = power_down_wake_reg;

endmodule

// ### tb/intc_sva.sv
// Purpose: port-level checks of the interrupt controller
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to the top module from the bench top file
`timescale 1ns/1ps
module intc_sva (
	input logic        clk,
	input logic        sys_rst,
	input logic [7:0]  sfr_addr,
	input logic        sfr_rd,
	input logic [7:0]  sfr_rdata,
	input logic        uart_pend,
	input logic        irq_ack,
	input logic        return_from_interrupt,
	input logic        idle_mode,
	input logic        power_down_mode,
	input logic        irq_req,
	input logic [3:0]  irq_vec_num,
	input logic [23:0] irq_vec_addr,
	input logic [4:0]  level_in_progress,
	input logic        idle_wake,
	input logic        power_down_wake
);
	// ----
	// request and nesting
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// acceptance must drop the request for at least a cycle
	AST_ACK_DROPS: assert property (irq_req && irq_ack |=> !irq_req)
		else $error("request stayed up after acceptance");
	AST_REQ_STANDS: assert property (irq_req && !irq_ack |=> irq_req)
		else $error("request withdrawn before acceptance");
	// a pushed level must sit above every running level
	AST_PUSH_HIGHER: assert property (irq_req && irq_ack && !return_from_interrupt
		|=> level_in_progress > $past(level_in_progress))
		else $error("accepted level not above running levels");
	AST_RETURN_POPS: assert property (return_from_interrupt && !irq_ack && level_in_progress != 5'h00
		|=> ($countones($past(level_in_progress)) == $countones(level_in_progress) + 1)
		&& (level_in_progress < ($past(level_in_progress) ^ level_in_progress)))
		else $error("return did not pop the top level");
	AST_VEC_SPACING: assert property (irq_req |-> irq_vec_addr[15:0] == {9'h000, irq_vec_num, 3'h3})
		else $error("vector address not eight-byte spaced");
	// ----
	// register reads and wake-up
	// ----
	AST_RSVD_BIT7: assert property (sfr_rd && sfr_addr inside {8'he8, 8'hb7, 8'hb8, 8'hf7, 8'hf8}
		|=> sfr_rdata[7] == 1'b0)
		else $error("reserved bit read as one");
	AST_EXT_UPPER: assert property (sfr_rd && sfr_addr == 8'hd8 |=> sfr_rdata[7:4] == 4'h0)
		else $error("external control upper bits not zero");
	AST_FLAG_LIVE: assert property (sfr_rd && sfr_addr == 8'h88 |=> sfr_rdata[4] == $past(uart_pend))
		else $error("group flag does not follow pending line");
	AST_PD_WAKE_MODE: assert property (power_down_wake |-> $past(power_down_mode))
		else $error("power-down wake outside power-down");
	AST_IDLE_WAKE_MODE: assert property (idle_wake |-> $past(idle_mode))
		else $error("idle wake outside idle");
endmodule

// ### tb/ext_source_model.sv
// Purpose: external requester driving both active-low request pins
// Assumes: pins pulled high when released
// Notes:   moves pins at falling clock edges only
`timescale 1ns/1ps
module ext_source_model (
	input  logic clk,
	output logic pin0_n = 1'b1,
	output logic pin1_n = 1'b1
);
	// ----
	// one request: high stretch, low stretch, release
	// ----
	task automatic drive_low(input int which, input int n);
		repeat (2) @(negedge clk);
		if (which == 0) pin0_n = 1'b0; else pin1_n = 1'b0;
		// long low keeps power-down wake-ups safe
		repeat (n) @(negedge clk);
		pin0_n = 1'b1;
		pin1_n = 1'b1;
	endtask
endmodule

// ### tb/four_level_interrupt_controller_tb_top.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: 100 MHz clock, inputs moved on falling edges
// Notes:   table rows cover every maskable peripheral source
`timescale 1ns/1ps
`include "intc_consts.vh"
module four_level_interrupt_controller_tb_top;
	// ----
	// stimulus and observation
	// ----
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [14:0] pend = 15'h0000;
	logic        nmi_req = 1'b0;
	logic        trap_req = 1'b0;
	logic        irq_ack = 1'b0;
	logic        ret = 1'b0;
	logic        bank = 1'b0;
	logic        idle_mode = 1'b0;
	logic        pd_mode = 1'b0;
	logic [7:0]  m;
	logic [7:0]  rd_val;
	wire  [7:0]  sfr_rdata;
	wire         pin0_n;
	wire         pin1_n;
	wire         irq_req;
	wire         idle_wake;
	wire         pd_wake;
	wire  [3:0]  vec_num;
	wire  [23:0] vec_addr;
	wire  [23:0] rst_vec;
	wire  [4:0]  lip;
	int          num_errors = 0;
	int          n_tests = 0;
	// rows: pend index, enable reg (0 primary, 1 additional), enable bit, vector
	logic [15:0] rows [15] = '{16'h0011, 16'h1033, 16'h2044, 16'h3055, 16'h4066, 16'h5108, 16'h6119,
		16'h712a, 16'h813b, 16'h914c, 16'ha14c, 16'hb14c, 16'hc14c, 16'hd15d, 16'he16e};
	logic [7:0]  raddr [10] = '{8'ha8, 8'he8, 8'hb7, 8'hb8, 8'hf7, 8'hf8, 8'hd8, 8'h88, 8'hc0, 8'h55};
	logic [7:0]  rexp [10] = '{8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h05, 8'h00, 8'h00, 8'h00};

	always #5 clk = ~clk;

	// converter causes share one line inside the design
	four_level_interrupt_controller i_dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.ext_request_pin_0(pin0_n), .ext_request_pin_1(pin1_n), .counter_timer_pend(pend[0]),
		.rtc_pend(pend[1]), .uart_pend(pend[2]), .infrared_receiver_pend(pend[3]), .spi_pend(pend[4]),
		.usb_pend(pend[5]), .dma5_pend(pend[6]), .dma4_pend(pend[7]), .lcd_pend(pend[8]),
		.wire_ctl_pend(pend[9]), .audio_adc_pend(pend[10]), .amp_overcurrent_pend(pend[11]),
		.classd_overcurrent_pend(pend[12]), .codec_pend(pend[13]), .dma012_pend(pend[14]),
		.nmi_req(nmi_req), .trap_req(trap_req), .irq_ack(irq_ack), .return_from_interrupt(ret),
		.vector_bank_hi(bank), .idle_mode(idle_mode), .power_down_mode(pd_mode), .irq_req(irq_req),
		.irq_vec_num(vec_num), .irq_vec_addr(vec_addr), .reset_vec_addr(rst_vec), .level_in_progress(lip),
		.idle_wake(idle_wake), .power_down_wake(pd_wake));
	ext_source_model i_src (.clk(clk), .pin0_n(pin0_n), .pin1_n(pin1_n));

	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	// read data lands at the taking edge and is sampled at the next falling edge
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		rd_val = sfr_rdata;
	endtask
	// which 0 accepts the request, 1 returns from the routine
	task automatic pulse(input int which);
		@(negedge clk);
		if (which == 0) irq_ack = 1'b1; else ret = 1'b1;
		@(negedge clk);
		irq_ack = 1'b0;
		ret = 1'b0;
	endtask
	task automatic summarize;
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		chk(rst_vec, 24'hfe_0000);
		foreach (rows[i]) begin
			m = 8'h01 << rows[i][7:4];
			bank = i[0];
			wr(`ADDR_PRIMARY_EN, 8'h80);
			wr(`ADDR_ADDITIONAL_EN, 8'h00);
			// raise pending only once the old enable is gone, else a standing request is withdrawn
			pend[rows[i][15:12]] = 1'b1;
			repeat (3) @(negedge clk);
			chk(irq_req, 1'b0);
			wr(rows[i][8] ? `ADDR_ADDITIONAL_EN : `ADDR_PRIMARY_EN, rows[i][8] ? m : (8'h80 | m));
			rd(rows[i][8] ? `ADDR_GROUP_FLAGS_B : `ADDR_GROUP_FLAGS_A);
			chk(rd_val, m);
			chk(irq_req, 1'b1);
			chk(vec_num, rows[i][3:0]);
			chk(vec_addr, {bank ? 8'hff : 8'hfe, 8'h00, 1'b0, rows[i][3:0], 3'h3});
			pulse(0);
			chk(lip, 5'h01);
			pend[rows[i][15:12]] = 1'b0;
			pulse(1);
			chk(lip, 5'h00);
		end
		foreach (raddr[i]) begin
			wr(raddr[i], 8'hff);
			rd(raddr[i]);
			chk(rd_val, rexp[i]);
			wr(raddr[i], 8'h00);
		end
		// uart level 2, spi level 1, global enable off at first
		wr(`ADDR_PRIMARY_EN, 8'h50);
		wr(`ADDR_PRIO_MSB_A, 8'h10);
		wr(`ADDR_PRIO_LSB_A, 8'h40);
		pend[2] = 1'b1;
		pend[4] = 1'b1;
		repeat (3) @(negedge clk);
		chk(irq_req, 1'b0);
		wr(`ADDR_PRIMARY_EN, 8'hd0);
		repeat (2) @(negedge clk);
		chk(vec_num, 4'h4);
		pulse(0);
		repeat (3) @(negedge clk);
		chk(irq_req, 1'b0);
		wr(`ADDR_PRIO_MSB_A, 8'h50);
		repeat (2) @(negedge clk);
		chk(vec_num, 4'h6);
		pulse(0);
		chk(lip, 5'h0c);
		pend[4] = 1'b0;
		pulse(1);
		chk(lip, 5'h04);
		pend[2] = 1'b0;
		pulse(1);
		// equal level, same cycle: fixed ranking decides
		wr(`ADDR_PRIO_MSB_A, 8'h00);
		wr(`ADDR_PRIO_LSB_A, 8'h00);
		pend[2] = 1'b1;
		pend[4] = 1'b1;
		repeat (3) @(negedge clk);
		chk(vec_num, 4'h6);
		pulse(0);
		pend = 15'h0000;
		pulse(1);
		// non-maskable sources with the global enable off
		wr(`ADDR_PRIMARY_EN, 8'h00);
		for (int k = 0; k < 2; k++) begin
			nmi_req = (k == 0);
			trap_req = (k == 1);
			repeat (3) @(negedge clk);
			chk(vec_num, k == 0 ? 4'h7 : 4'hf);
			pulse(0);
			chk(lip, 5'h10);
			nmi_req = 1'b0;
			trap_req = 1'b0;
			pulse(1);
		end
		// pin 0 falling edge: flag cleared on acceptance
		wr(`ADDR_EXT_CTRL, 8'h01);
		wr(`ADDR_PRIMARY_EN, 8'h81);
		i_src.drive_low(0, 3);
		repeat (2) @(negedge clk);
		rd(`ADDR_EXT_CTRL);
		chk(rd_val, 8'h03);
		chk(vec_num, 4'h0);
		pulse(0);
		rd(`ADDR_EXT_CTRL);
		chk(rd_val, 8'h01);
		pulse(1);
		// pin 1 low level: flag stays until written with one
		wr(`ADDR_EXT_CTRL, 8'h00);
		wr(`ADDR_PRIMARY_EN, 8'h84);
		i_src.drive_low(1, 4);
		repeat (2) @(negedge clk);
		chk(vec_num, 4'h2);
		pulse(0);
		rd(`ADDR_EXT_CTRL);
		chk(rd_val, 8'h08);
		wr(`ADDR_EXT_CTRL, 8'h08);
		rd(`ADDR_EXT_CTRL);
		chk(rd_val, 8'h00);
		pulse(1);
		// a peripheral wakes idle but not power-down; a pin wakes power-down
		wr(`ADDR_PRIMARY_EN, 8'h88);
		pend[1] = 1'b1;
		pd_mode = 1'b1;
		repeat (3) @(negedge clk);
		chk(pd_wake, 1'b0);
		idle_mode = 1'b1;
		repeat (2) @(negedge clk);
		chk(idle_wake, 1'b1);
		wr(`ADDR_PRIMARY_EN, 8'h89);
		i_src.drive_low(0, 8);
		@(negedge clk);
		chk(pd_wake, 1'b1);
		// second reset in mid-run restores every register
		pend = 15'h0000;
		idle_mode = 1'b0;
		pd_mode = 1'b0;
		sys_rst = 1'b1;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		chk(vec_addr, 24'hfe_0000);
		chk(rst_vec, 24'hfe_0000);
		chk(lip, 5'h00);
		foreach (raddr[i]) begin
			rd(raddr[i]);
			chk(rd_val, 8'h00);
		end
		summarize();
	end

	// watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule

bind four_level_interrupt_controller intc_sva i_sva (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
	.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .uart_pend(uart_pend), .irq_ack(irq_ack),
	.return_from_interrupt(return_from_interrupt), .idle_mode(idle_mode), .power_down_mode(power_down_mode),
	.irq_req(irq_req), .irq_vec_num(irq_vec_num), .irq_vec_addr(irq_vec_addr),
	.level_in_progress(level_in_progress), .idle_wake(idle_wake), .power_down_wake(power_down_wake));
